/* design/pcd_params.svh */
// register offsets, field positions and reset values of the phy diagnostic/special registers
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH
`define PCD_PHY_FIRST 5'h01
// cable_diag_ctrl_status
`define PCD_REG_DIAG 5'h1d
// phy_special_ctrl_status
`define PCD_REG_SPEC 5'h1f
`define PCD_SW_PORT1 4'h1
`define PCD_SW_OFF_DIAG 4'ha
`define PCD_SW_OFF_COUNT 4'hb
`define PCD_SW_OFF_FAR 4'hd
`define PCD_SW_OFF_MDIX 4'he
`define PCD_SW_OFF_POL 4'hf
`define PCD_B_EN 15
`define PCD_B_RES_HI 14
`define PCD_B_RES_LO 13
`define PCD_B_SHORT 12
`define PCD_B_CNT_HI 8
`define PCD_B_CNT_LO 0
`define PCD_B_POL 5
`define PCD_B_MDIX 4
`define PCD_B_FORCE 3
`define PCD_B_PWR 2
`define PCD_B_LOOP 1
`define PCD_B_RSVD 0
`define PCD_SB_SHORT 7
`define PCD_SB_RES_HI 6
`define PCD_SB_RES_LO 5
`define PCD_SB_EN 4
`define PCD_SB_FAR 4
`define PCD_SB_MDIX 7
`define PCD_SB_POL 5
`define PCD_SB_CNT8 0
`define PCD_PWR_DIS_RST 1'b1
`define PCD_FAULT_STEP_DM 4
`endif

/* design/pcd_pkg.sv */
// types shared by the phy diagnostic/special register bank
package pcd_pkg;
	typedef enum logic [1:0] {
		PCD_NORMAL,
		PCD_OPEN,
		PCD_SHORT,
		PCD_FAILED
	} pcd_result_t;
	typedef struct packed {
		pcd_result_t result;
		logic near_short;
		logic [8:0] count;
	} pcd_diag_stat_t;
	typedef struct packed {
		logic pol_rev;
		logic mdix;
	} pcd_line_t;
	typedef struct packed {
		logic far_dis;
		logic force_link;
		logic pwr_dis;
		logic remote_loop;
		logic rsvd0;
	} pcd_ctl_t;
	typedef enum logic {
		PCD_IDLE,
		PCD_RUN
	} pcd_state_t;
endpackage : pcd_pkg

/* design/pcd_regs.sv */
// per-phy cable diagnostic and special control registers, mii and 8-bit switch views
// How it works
// - each of the two phys (address 1 and 2) has its own diagnostic (0x1d) and special (0x1f) register.
// - writing one to bit 15 starts the cable test and the bit reads back zero once it finishes.
// - bits 14-13 give the result: normal, open, short or test failed, resetting to normal.
// - read-only bit 12 shows a short nearer than ten metres and resets to zero.
// - bits 8-0 give the fault distance in steps of about 0.4 m, resetting to zero.
// - read-only bit 5 of the special register shows reversed receive polarity.
// - bit 3 of the special register forces the link to pass.
// - bit 2 disables power saving when one and resets to one.
// - bit 1 loops the port's receive pair back out through its own transmit pair.
// - port 1 phy control and status also appear in switch bytes 0x10-0x1d and 0x1e-0x1f.
// - port 2 phy control and status also appear in switch bytes 0x20-0x2d and 0x2e-0x2f.
// - a separate bit disables far-end fault detection when one.
`timescale 1ns/1ps
`include "pcd_params.svh"
module pcd_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// mii management access
	input wire logic mii_req,
	input wire logic mii_wr,
	input wire logic [4:0] phy_select,
	input wire logic [4:0] reg_select,
	input wire logic [15:0] mii_wdata,
	output logic [15:0] mii_rdata_q,
	output logic mii_rvalid_q,
	// switch byte register access
	input wire logic sw_req,
	input wire logic sw_wr,
	input wire logic [7:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	output logic [7:0] sw_rdata_q,
	output logic sw_rvalid_q,
	// phy analog side, index 0 is port 1
	output logic [1:0] diag_start_q,
	input wire logic [1:0] diag_done,
	input wire pcd_pkg::pcd_diag_stat_t [1:0] diag_in,
	input wire pcd_pkg::pcd_line_t [1:0] line_in,
	output pcd_pkg::pcd_ctl_t [1:0] phy_ctl_q
);
	pcd_pkg::pcd_state_t [1:0] st_q, st_d;
	pcd_pkg::pcd_diag_stat_t [1:0] stat_q, stat_d;
	pcd_pkg::pcd_ctl_t [1:0] ctl_d;
	logic [1:0] start_d;
	logic [15:0] mii_rdata_d;
	logic [7:0] sw_rdata_d;
	logic mii_rvalid_d, sw_rvalid_d;
	logic [1:0] busy;
	logic [1:0] go;
	logic [1:0] mii_hit;
	logic [1:0] sw_hit;

	assign busy[0] = st_q[0] == pcd_pkg::PCD_RUN;
	assign busy[1] = st_q[1] == pcd_pkg::PCD_RUN;

	function automatic logic [15:0] diag_word(input logic b, input pcd_pkg::pcd_diag_stat_t s);
		logic [15:0] w;
		w = '0;
		w[`PCD_B_EN] = b;
		w[`PCD_B_RES_HI:`PCD_B_RES_LO] = s.result;
		w[`PCD_B_SHORT] = s.near_short;
		w[`PCD_B_CNT_HI:`PCD_B_CNT_LO] = s.count;
		return w;
	endfunction : diag_word

	always_comb begin
		st_d = st_q;
		stat_d = stat_q;
		ctl_d = phy_ctl_q;
		start_d = 2'h0;
		go = 2'h0;
		mii_hit = 2'h0;
		sw_hit = 2'h0;
		mii_rdata_d = 16'h0000;
		sw_rdata_d = 8'h00;
		// valid pulses for every read, mapped or not, so a host never waits
		mii_rvalid_d = mii_req && !mii_wr;
		sw_rvalid_d = sw_req && !sw_wr;
		for (int i = 0; i < 2; i++) begin
			mii_hit[i] = mii_req && phy_select == `PCD_PHY_FIRST + 5'(i);
			sw_hit[i] = sw_req && sw_addr[7:4] == `PCD_SW_PORT1 + 4'(i);
			go[i] = (mii_hit[i] && mii_wr && reg_select == `PCD_REG_DIAG && mii_wdata[`PCD_B_EN])
				|| (sw_hit[i] && sw_wr && sw_addr[3:0] == `PCD_SW_OFF_DIAG && sw_wdata[`PCD_SB_EN]);
			// mii wins a same-cycle write collision on the shared control bits
			if (mii_hit[i] && mii_wr && reg_select == `PCD_REG_SPEC) begin
				ctl_d[i].force_link = mii_wdata[`PCD_B_FORCE];
				ctl_d[i].pwr_dis = mii_wdata[`PCD_B_PWR];
				ctl_d[i].remote_loop = mii_wdata[`PCD_B_LOOP];
				ctl_d[i].rsvd0 = mii_wdata[`PCD_B_RSVD];
			end else if (sw_hit[i] && sw_wr && sw_addr[3:0] == `PCD_SW_OFF_DIAG) begin
				ctl_d[i].force_link = sw_wdata[`PCD_B_FORCE];
				ctl_d[i].pwr_dis = sw_wdata[`PCD_B_PWR];
				ctl_d[i].remote_loop = sw_wdata[`PCD_B_LOOP];
			end
			if (sw_hit[i] && sw_wr && sw_addr[3:0] == `PCD_SW_OFF_FAR) begin
				ctl_d[i].far_dis = sw_wdata[`PCD_SB_FAR];
			end
			unique case (st_q[i])
				pcd_pkg::PCD_IDLE: begin
					if (go[i]) begin
						st_d[i] = pcd_pkg::PCD_RUN;
						start_d[i] = 1'b1;
					end
				end
				pcd_pkg::PCD_RUN: begin
					// new starts ignored here, results held until done
					if (diag_done[i]) begin
						st_d[i] = pcd_pkg::PCD_IDLE;
						stat_d[i] = diag_in[i];
					end
				end
			endcase
			if (mii_hit[i] && !mii_wr && reg_select == `PCD_REG_DIAG) begin
				mii_rdata_d = diag_word(busy[i], stat_q[i]);
			end
			if (mii_hit[i] && !mii_wr && reg_select == `PCD_REG_SPEC) begin
				mii_rdata_d[`PCD_B_POL] = line_in[i].pol_rev;
				mii_rdata_d[`PCD_B_MDIX] = line_in[i].mdix;
				mii_rdata_d[`PCD_B_FORCE] = phy_ctl_q[i].force_link;
				mii_rdata_d[`PCD_B_PWR] = phy_ctl_q[i].pwr_dis;
				mii_rdata_d[`PCD_B_LOOP] = phy_ctl_q[i].remote_loop;
				mii_rdata_d[`PCD_B_RSVD] = phy_ctl_q[i].rsvd0;
			end
			if (sw_hit[i] && !sw_wr) begin
				unique case (sw_addr[3:0])
					`PCD_SW_OFF_DIAG: begin
						sw_rdata_d[`PCD_SB_SHORT] = stat_q[i].near_short;
						sw_rdata_d[`PCD_SB_RES_HI:`PCD_SB_RES_LO] = stat_q[i].result;
						sw_rdata_d[`PCD_SB_EN] = busy[i];
						sw_rdata_d[`PCD_B_FORCE] = phy_ctl_q[i].force_link;
						sw_rdata_d[`PCD_B_PWR] = phy_ctl_q[i].pwr_dis;
						sw_rdata_d[`PCD_B_LOOP] = phy_ctl_q[i].remote_loop;
						sw_rdata_d[`PCD_SB_CNT8] = stat_q[i].count[8];
					end
					`PCD_SW_OFF_COUNT: sw_rdata_d = stat_q[i].count[7:0];
					`PCD_SW_OFF_FAR: sw_rdata_d[`PCD_SB_FAR] = phy_ctl_q[i].far_dis;
					`PCD_SW_OFF_MDIX: sw_rdata_d[`PCD_SB_MDIX] = line_in[i].mdix;
					`PCD_SW_OFF_POL: sw_rdata_d[`PCD_SB_POL] = line_in[i].pol_rev;
					default: sw_rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_q[0] <= pcd_pkg::PCD_IDLE;
			st_q[1] <= pcd_pkg::PCD_IDLE;
			stat_q <= '0;
			phy_ctl_q <= '0;
			phy_ctl_q[0].pwr_dis <= `PCD_PWR_DIS_RST;
			phy_ctl_q[1].pwr_dis <= `PCD_PWR_DIS_RST;
			diag_start_q <= 2'h0;
			mii_rdata_q <= 16'h0000;
			mii_rvalid_q <= 1'b0;
			sw_rdata_q <= 8'h00;
			sw_rvalid_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			stat_q <= stat_d;
			phy_ctl_q <= ctl_d;
			diag_start_q <= start_d;
			mii_rdata_q <= mii_rdata_d;
			mii_rvalid_q <= mii_rvalid_d;
			sw_rdata_q <= sw_rdata_d;
			sw_rvalid_q <= sw_rvalid_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_start_once;
		clk_en && !busy[0] && go[0] |=> diag_start_q[0] && busy[0];
	endproperty
	a_start_once: assert property (p_start_once) else $error("test did not start");
	property p_done_clears;
		clk_en && busy[0] && diag_done[0] |=> !busy[0] && stat_q[0] == $past(diag_in[0]);
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("result not latched");
	property p_hold_running;
		clk_en && busy[0] && !diag_done[0] |=> busy[0] && !diag_start_q[0] && $stable(stat_q[0]);
	endproperty
	a_hold_running: assert property (p_hold_running) else $error("running test disturbed");
	property p_diag_read;
		clk_en && mii_req && !mii_wr && phy_select == 5'h01 && reg_select == 5'h1d
			|=> mii_rvalid_q && mii_rdata_q[15] == $past(busy[0])
			&& mii_rdata_q[8:0] == $past(stat_q[0].count);
	endproperty
	a_diag_read: assert property (p_diag_read) else $error("diag read mismatch");
	property p_pol_read;
		clk_en && mii_req && !mii_wr && phy_select == 5'h02 && reg_select == 5'h1f
			|=> mii_rdata_q[5] == $past(line_in[1].pol_rev) && mii_rdata_q[15:6] == 10'h000;
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("polarity read mismatch");
	property p_spec_write;
		clk_en && mii_req && mii_wr && phy_select == 5'h01 && reg_select == 5'h1f
			|=> phy_ctl_q[0].force_link == $past(mii_wdata[3])
			&& phy_ctl_q[0].pwr_dis == $past(mii_wdata[2])
			&& phy_ctl_q[0].remote_loop == $past(mii_wdata[1]);
	endproperty
	a_spec_write: assert property (p_spec_write) else $error("special write lost");
	property p_sw_pol;
		clk_en && sw_req && !sw_wr && sw_addr == 8'h1f |=> sw_rvalid_q
			&& sw_rdata_q[5] == $past(line_in[0].pol_rev);
	endproperty
	a_sw_pol: assert property (p_sw_pol) else $error("port 1 mirror mismatch");
	property p_sw_far;
		clk_en && sw_req && sw_wr && sw_addr == 8'h2d |=> phy_ctl_q[1].far_dis == $past(sw_wdata[4]);
	endproperty
	a_sw_far: assert property (p_sw_far) else $error("port 2 far-end bit lost");
	property p_pwr_reset;
		$fell(reset) |-> phy_ctl_q[0].pwr_dis && phy_ctl_q[1].pwr_dis && stat_q == '0;
	endproperty
	a_pwr_reset: assert property (@(posedge clk) p_pwr_reset) else $error("bad reset value");
	c_test_ends: cover property (busy[0] ##[1:1000] !busy[0]);
	c_start_ignored: cover property (busy[1] && go[1]);
	c_loopback: cover property (phy_ctl_q[1].remote_loop);
endmodule : pcd_regs

/* dv/test_pcd_regs.sv */
// self-checking bench for the phy diagnostic/special register bank
`timescale 1ns/1ps
module test_pcd_regs;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic mii_req = 1'b0, mii_wr = 1'b0, sw_req = 1'b0, sw_wr = 1'b0;
	logic [4:0] phy_select = 5'h01, reg_select = 5'h1d;
	logic [15:0] mii_wdata = 16'h0000, mii_rdata_q, rd;
	logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata_q, rb, b;
	logic mii_rvalid_q, sw_rvalid_q;
	logic rv, rvb;
	logic clk_en = 1'b1;
	logic [1:0] diag_start_q, st, diag_done = 2'h0;
	pcd_pkg::pcd_diag_stat_t [1:0] diag_in = '0, ds;
	pcd_pkg::pcd_line_t [1:0] line_in = '0;
	pcd_pkg::pcd_ctl_t [1:0] phy_ctl_q, cx;
	integer seed = 32'he30b6264;
	int miscompares = 0, compares = 0, cycles = 0, p;

	pcd_regs pcd_regs_i (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.mii_req(mii_req),
		.mii_wr(mii_wr),
		.phy_select(phy_select),
		.reg_select(reg_select),
		.mii_wdata(mii_wdata),
		.mii_rdata_q(mii_rdata_q),
		.mii_rvalid_q(mii_rvalid_q),
		.sw_req(sw_req),
		.sw_wr(sw_wr),
		.sw_addr(sw_addr),
		.sw_wdata(sw_wdata),
		.sw_rdata_q(sw_rdata_q),
		.sw_rvalid_q(sw_rvalid_q),
		.diag_start_q(diag_start_q),
		.diag_done(diag_done),
		.diag_in(diag_in),
		.line_in(line_in),
		.phy_ctl_q(phy_ctl_q)
	);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end

	task complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task chk_w(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_w

	task chk_b(input logic [7:0] g, input logic [7:0] e);
		chk_w({8'h00, g}, {8'h00, e});
	endtask : chk_b

	// request lowered one edge before the next access may raise it again
	task mii(input logic w, input int ph, input logic [4:0] r, input logic [15:0] d);
		mii_req = 1'b1;
		mii_wr = w;
		phy_select = 5'(ph);
		reg_select = r;
		mii_wdata = d;
		@(posedge clk);
		#2 rd = mii_rdata_q;
		rv = mii_rvalid_q;
		st = diag_start_q;
		mii_req = 1'b0;
		@(posedge clk);
		#2;
	endtask : mii

	task sw(input logic w, input logic [7:0] a, input logic [7:0] d);
		sw_req = 1'b1;
		sw_wr = w;
		sw_addr = a;
		sw_wdata = d;
		@(posedge clk);
		#2 rb = sw_rdata_q;
		rvb = sw_rvalid_q;
		st = diag_start_q;
		sw_req = 1'b0;
		@(posedge clk);
		#2;
	endtask : sw

	task pulse_done;
		diag_done[p] = 1'b1;
		@(posedge clk);
		#2 diag_done[p] = 1'b0;
	endtask : pulse_done

	function automatic logic [15:0] dw(input pcd_pkg::pcd_diag_stat_t s, input logic run);
		return {run, s.result, s.near_short, 3'h0, s.count};
	endfunction : dw

	function automatic logic [15:0] spw(input pcd_pkg::pcd_ctl_t c, input pcd_pkg::pcd_line_t l);
		return {10'h0, l.pol_rev, l.mdix, c.force_link, c.pwr_dis, c.remote_loop, c.rsvd0};
	endfunction : spw

	function automatic logic [7:0] swd(input pcd_pkg::pcd_diag_stat_t s, input pcd_pkg::pcd_ctl_t c);
		return {s.near_short, s.result, 1'b0, c.force_link, c.pwr_dis, c.remote_loop, s.count[8]};
	endfunction : swd

	initial begin
		repeat (4) @(posedge clk);
		#2 reset = 1'b0;
		cx = {5'h04, 5'h04};
		ds = '0;
		for (p = 0; p < 2; p++) begin
			mii(1'b0, p + 1, 5'h1d, 16'h0000);
			chk_w(rd, 16'h0000);
			mii(1'b0, p + 1, 5'h1f, 16'h0000);
			chk_w(rd, 16'h0004);
		end
		for (int i = 0; i < 8; i++) begin
			p = i % 2;
			b = 8'(16 + 16 * p);
			cx[p] = 5'($random(seed));
			cx[p].rsvd0 = 1'b0;
			line_in = 4'($random(seed));
			mii(1'b1, p + 1, 5'h1f, {12'h0, cx[p][3:0]});
			chk_w({15'h0, rv}, 16'h0000);
			sw(1'b1, b + 8'h0d, {3'h0, cx[p].far_dis, 4'h0});
			mii(1'b0, p + 1, 5'h1f, 16'h0000);
			chk_w(rd, spw(cx[p], line_in[p]));
			chk_w({15'h0, rv}, 16'h0001);
			chk_w({11'h0, phy_ctl_q[p]}, {11'h0, cx[p]});
			sw(1'b0, b + 8'h0d, 8'h00);
			chk_b(rb, {3'h0, cx[p].far_dis, 4'h0});
			sw(1'b0, b + 8'h0f, 8'h00);
			chk_b(rb, {2'h0, line_in[p].pol_rev, 5'h0});
			chk_b({7'h0, rvb}, 8'h01);
			sw(1'b0, b + 8'h0e, 8'h00);
			chk_b(rb, {line_in[p].mdix, 7'h0});
		end
		// one test per result code, alternating phys
		for (int r = 0; r < 4; r++) begin
			p = r % 2;
			b = 8'(16 + 16 * p);
			mii(1'b1, p + 1, 5'h1d, 16'h8000);
			chk_w({14'h0, st}, 16'(1 << p));
			mii(1'b1, p + 1, 5'h1d, 16'h8000);
			chk_w({14'h0, st}, 16'h0000);
			diag_in[p] = 12'($random(seed));
			mii(1'b0, p + 1, 5'h1d, 16'h0000);
			chk_w(rd, dw(ds[p], 1'b1));
			diag_in[p].result = pcd_pkg::pcd_result_t'(r);
			ds[p] = diag_in[p];
			pulse_done();
			diag_in[p] = 12'($random(seed));
			mii(1'b0, p + 1, 5'h1d, 16'h0000);
			chk_w(rd, dw(ds[p], 1'b0));
			sw(1'b0, b + 8'h0a, 8'h00);
			chk_b(rb, swd(ds[p], cx[p]));
			sw(1'b0, b + 8'h0b, 8'h00);
			chk_b(rb, ds[p].count[7:0]);
			// completion while idle must not disturb the results
			pulse_done();
			mii(1'b0, p + 1, 5'h1d, 16'h0000);
			chk_w(rd, dw(ds[p], 1'b0));
		end
		// start through the switch byte view, control bits written alongside
		for (p = 0; p < 2; p++) begin
			b = 8'(16 + 16 * p);
			cx[p][3:1] = 3'($random(seed));
			sw(1'b1, b + 8'h0a, {3'h0, 1'b1, cx[p][3:1], 1'b0});
			chk_w({14'h0, st}, 16'(1 << p));
			chk_w({11'h0, phy_ctl_q[p]}, {11'h0, cx[p]});
			diag_in[p] = 12'($random(seed));
			ds[p] = diag_in[p];
			pulse_done();
			mii(1'b0, p + 1, 5'h1d, 16'h0000);
			chk_w(rd, dw(ds[p], 1'b0));
		end
		// frozen clock enable: a write must leave the controls alone
		clk_en = 1'b0;
		mii(1'b1, 1, 5'h1f, {12'h0, ~cx[0][3:1], 1'b0});
		clk_en = 1'b1;
		chk_w({11'h0, phy_ctl_q[0]}, {11'h0, cx[0]});
		// second reset mid-run restores defaults
		reset = 1'b1;
		@(posedge clk);
		#2 reset = 1'b0;
		mii(1'b0, 2, 5'h1f, 16'h0000);
		chk_w(rd, spw(5'h04, line_in[1]));
		mii(1'b0, 1, 5'h1d, 16'h0000);
		chk_w(rd, 16'h0000);
		mii(1'b0, 3, 5'h1d, 16'h0000);
		chk_w(rd, 16'h0000);
		mii(1'b0, 1, 5'h1e, 16'h0000);
		chk_w(rd, 16'h0000);
		sw(1'b0, 8'h30, 8'h00);
		chk_b(rb, 8'h00);
		complete_run();
	end
endmodule : test_pcd_regs
